// ===== rcd_datapath.sv
// rcd_datapath: rotate datapath with an axi4-lite register port
// assumes the decoder writes operand, count and env before the insn word
// Functional notes
// [RULE_01] decode d0/d2/c0 byte, d1/d3/c1 word
// [RULE_02] reg field 0..3 picks the rotate
// [RULE_03] carry joins loop: 9 or 17 bits
// [RULE_04] left step wraps top into bottom
// [RULE_05] right step wraps bottom into top
// [RULE_06] left-thru-carry: carry in, top out
// [RULE_07] right-thru-carry: carry in, bottom out
// [RULE_08] plain rotates copy wrapped bit to carry
// [RULE_09] count from immediate, count register, or one
// [RULE_10] count masked to low five bits
// [RULE_11] overflow only for single-step forms
// [RULE_12] right-thru-carry tests before, others after
// [RULE_13] overflow = carry differs from top bit
// [RULE_14] only carry and overflow flags change
// [RULE_15] cycles: 2/7 or 5/8 plus steps
// [RULE_16] protected non-writable target gives protection fault
// [RULE_17] bad address: protection fault, stack fault
// [RULE_18] real mode word at last offset: int13
// [RULE_19] memory operand written back unless faulted; the code also skips the write-back for a zero count
// [RULE_20] zero count leaves operand and flags
`default_nettype none
module rcd_datapath
  import rcd_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // memory write-back
  output logic             wb_valid,
  output logic      [15:0] wb_data
);
  // held bus requests
  logic          aw_hold;
  logic          w_hold;
  logic [7:0]    aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          next_aw_hold;
  logic          next_w_hold;
  logic          do_write;
  logic          wr_mapped;
  logic [31:0]   wr_mask;
  // software visible state
  logic [31:0]   insn;
  logic [15:0]   operand;
  logic [7:0]    count_register_low_byte;
  logic [15:0]   flags;
  logic [31:0]   env;
  logic [15:0]   result;
  logic [7:0]    status;
  logic [7:0]    cycles_used;
  // execution state
  rcd_state_type state;
  rcd_kind_type  kind;
  logic          is_word;
  logic          single;
  logic          is_mem;
  logic [15:0]   work;
  logic          work_cf;
  logic          orig_cf;
  logic          orig_top;
  logic [4:0]    steps_left;
  logic [5:0]    cyc_left;
  logic          zero_count;
  // start decode
  logic [7:0]    st_op;
  logic          st_valid;
  logic          st_word;
  logic          st_single;
  logic [7:0]    st_raw;
  logic [4:0]    st_count;
  logic [5:0]    st_base;
  logic          st_gp;
  logic          st_ss;
  logic          st_int13;
  logic          start;
  // step outputs
  logic [15:0]   step_data;
  logic          step_cf;
  logic          res_top;

  // address/data acceptance in either order
  always_comb begin
    do_write     = aw_hold && w_hold && !bvalid;
    next_aw_hold = do_write ? 1'b0 : (aw_hold || (awvalid && awready));
    next_w_hold  = do_write ? 1'b0 : (w_hold || (wvalid && wready));
  end

  // ready drops once an item is held, so only one write is open
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold  <= next_w_hold;
      awready <= !next_aw_hold;
      wready  <= !next_w_hold;
      if (awvalid && awready) begin
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
    end
  end

  // byte lane mask and map check
  always_comb begin
    wr_mask   = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wr_mapped = (aw_addr == RCD_OFS_INSN) || (aw_addr == RCD_OFS_OPERAND) ||
                (aw_addr == RCD_OFS_COUNT) || (aw_addr == RCD_OFS_FLAGS) ||
                (aw_addr == RCD_OFS_ENV);
  end

  // write response, slverr on unmapped or read-only offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= 2'h0;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_mapped ? 2'h0 : 2'h2;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel, one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= 2'h0;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= 2'h0;
      case (araddr)
        RCD_OFS_INSN:    rdata <= insn;
        RCD_OFS_OPERAND: rdata <= {16'h0000, operand};
        RCD_OFS_COUNT:   rdata <= {24'h000000, count_register_low_byte};
        RCD_OFS_FLAGS:   rdata <= {16'h0000, flags};
        RCD_OFS_ENV:     rdata <= env;
        RCD_OFS_STATUS:  rdata <= {16'h0000, cycles_used, status};
        RCD_OFS_RESULT:  rdata <= {16'h0000, result};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= 2'h2;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // decode of the insn word being written
  always_comb begin
    st_op     = w_data[7:0];
    // [RULE_01] six primary opcodes accepted
    st_valid  = (w_data[10:8] < 3'h4) &&
                ((st_op == RCD_OP_ONE_B) || (st_op == RCD_OP_ONE_W) ||
                 (st_op == RCD_OP_CNT_B) || (st_op == RCD_OP_CNT_W) ||
                 (st_op == RCD_OP_IMM_B) || (st_op == RCD_OP_IMM_W));
    st_word   = st_op[0];
    st_single = (st_op == RCD_OP_ONE_B) || (st_op == RCD_OP_ONE_W);
    // [RULE_09] count source by opcode
    if (st_single) begin
      st_raw = 8'h01;
    end else if ((st_op == RCD_OP_CNT_B) || (st_op == RCD_OP_CNT_W)) begin
      st_raw = count_register_low_byte;
    end else begin
      st_raw = w_data[23:16];
    end
    // [RULE_10] mask to five bits
    st_count = 5'(st_raw & RCD_COUNT_MASK);
    // [RULE_15] base cycle figure
    if (env[RCD_ENV_MEM]) begin
      st_base = st_single ? RCD_CYC_ONE_MEM : RCD_CYC_CNT_MEM;
    end else begin
      st_base = st_single ? RCD_CYC_ONE_REG : RCD_CYC_CNT_REG;
    end
    // [RULE_17] bad address fault by segment
    st_ss = env[RCD_ENV_PROT] && env[RCD_ENV_MEM] && env[RCD_ENV_EABAD] &&
            (env[RCD_ENV_SEG_LO+1:RCD_ENV_SEG_LO] == RCD_SEG_STACK);
    st_gp = env[RCD_ENV_PROT] && env[RCD_ENV_MEM] && env[RCD_ENV_EABAD] && !st_ss;
    // [RULE_16] non-writable target
    if (env[RCD_ENV_PROT] && env[RCD_ENV_MEM] && !env[RCD_ENV_WRABLE]
        && !env[RCD_ENV_EABAD]) begin
      st_gp = 1'b1;
    end
    // [RULE_18] word wraps past last offset
    st_int13 = !env[RCD_ENV_PROT] && env[RCD_ENV_MEM] && st_word && env[RCD_ENV_LASTB];
    start    = do_write && (aw_addr == RCD_OFS_INSN) && (state == RCD_IDLE);
  end

  // plain software registers, held while an operation runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      insn                    <= 32'h0000_0000;
      count_register_low_byte <= 8'h00;
      env                     <= RCD_ENV_RST;
    end else if (do_write && (state == RCD_IDLE)) begin
      if (aw_addr == RCD_OFS_INSN) begin
        insn <= (insn & ~wr_mask) | (w_data & wr_mask);
      end
      if (aw_addr == RCD_OFS_COUNT) begin
        count_register_low_byte <= 8'((count_register_low_byte & ~wr_mask[7:0]) |
                                      (w_data[7:0] & wr_mask[7:0]));
      end
      if (aw_addr == RCD_OFS_ENV) begin
        env <= (env & ~wr_mask) | (w_data & wr_mask);
      end
    end
  end

  // single rotate step on the working value
  rcd_step u_step (
    .data_in   (work),
    .carry_in  (work_cf),
    .is_word   (is_word),
    .kind      (kind),
    .data_out  (step_data),
    .carry_out (step_cf)
  );

  // top bit of the finished value
  assign res_top = is_word ? work[15] : work[7];

  // sequencer: one step per cycle, then pad to the cycle figure
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= RCD_IDLE;
      kind       <= RCD_ROL;
      is_word    <= 1'b0;
      single     <= 1'b0;
      is_mem     <= 1'b0;
      work       <= 16'h0000;
      work_cf    <= 1'b0;
      orig_cf    <= 1'b0;
      orig_top   <= 1'b0;
      steps_left <= 5'h00;
      cyc_left   <= 6'h00;
      zero_count <= 1'b0;
    end else begin
      case (state)
        RCD_IDLE: begin
          if (start && st_valid && !st_gp && !st_ss && !st_int13) begin
            state      <= RCD_RUN;
            // [RULE_02] reg field picks the kind
            kind       <= rcd_kind_type'(w_data[9:8]);
            is_word    <= st_word;
            single     <= st_single;
            is_mem     <= env[RCD_ENV_MEM];
            work       <= st_word ? operand : {8'h00, operand[7:0]};
            // [RULE_03] carry is the extra loop bit
            work_cf    <= flags[RCD_CARRY_BIT];
            orig_cf    <= flags[RCD_CARRY_BIT];
            orig_top   <= st_word ? operand[15] : operand[7];
            steps_left <= st_count;
            cyc_left   <= 6'(st_base + {1'b0, st_count} - 6'h01);
            zero_count <= (st_count == 5'h00);
          end
        end
        RCD_RUN: begin
          if (steps_left != 5'h00) begin
            work       <= step_data;
            work_cf    <= step_cf;
            steps_left <= 5'(steps_left - 5'h01);
          end
          if (cyc_left == 6'h00) begin
            state <= RCD_IDLE;
          end else begin
            cyc_left <= 6'(cyc_left - 6'h01);
          end
        end
        default: state <= RCD_IDLE;
      endcase
    end
  end

  // operand, result and flags; commit in the last run cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      operand <= 16'h0000;
      result  <= 16'h0000;
      flags   <= RCD_FLAGS_RST;
    end else if (state == RCD_IDLE) begin
      if (do_write && (aw_addr == RCD_OFS_OPERAND)) begin
        operand <= 16'((operand & ~wr_mask[15:0]) | (w_data[15:0] & wr_mask[15:0]));
      end
      if (do_write && (aw_addr == RCD_OFS_FLAGS)) begin
        flags <= 16'((flags & ~wr_mask[15:0]) | (w_data[15:0] & wr_mask[15:0]));
      end
    end else if ((cyc_left == 6'h00) && (steps_left == 5'h00)) begin
      // [RULE_20] zero count changes nothing
      if (!zero_count) begin
        operand <= work;
        result  <= work;
        // [RULE_14] only carry and overflow touched
        flags[RCD_CARRY_BIT] <= work_cf;
        // [RULE_11] multi-step leaves overflow as is
        if (single) begin
          // [RULE_12] right-thru-carry tests the input
          // [RULE_13] overflow when carry differs from top
          flags[RCD_OVF_BIT] <= (kind == RCD_RCR) ? (orig_cf ^ orig_top)
                                                  : (work_cf ^ res_top);
        end
      end
    end
  end

  // status flags; a new start clears the previous outcome
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status      <= 8'h00;
      cycles_used <= 8'h00;
      wb_valid    <= 1'b0;
      wb_data     <= 16'h0000;
    end else begin
      wb_valid <= 1'b0;
      if (start) begin
        status              <= 8'h00;
        cycles_used         <= 8'h00;
        status[RCD_ST_DONE] <= !st_valid || st_gp || st_ss || st_int13;
        status[RCD_ST_BUSY] <= st_valid && !st_gp && !st_ss && !st_int13;
        status[RCD_ST_BADOP] <= !st_valid;
        status[RCD_ST_GP]   <= st_valid && st_gp;
        status[RCD_ST_SS]   <= st_valid && st_ss;
        status[RCD_ST_INT13] <= st_valid && st_int13;
      end else if (state == RCD_RUN) begin
        cycles_used <= 8'(cycles_used + 8'h01);
        if (cyc_left == 6'h00) begin
          status[RCD_ST_BUSY] <= 1'b0;
          status[RCD_ST_DONE] <= 1'b1;
          // [RULE_19] write back only on faultless memory run
          if (is_mem && !zero_count) begin
            status[RCD_ST_WB] <= 1'b1;
            wb_valid          <= 1'b1;
            wb_data           <= work;
          end
        end
      end
    end
  end
endmodule : rcd_datapath
`default_nettype wire

// ===== rcd_datapath_bench.sv
// rcd_datapath_bench: register-level tests of the rotate datapath
// assumes the sink stands for memory
`default_nettype none
module rcd_datapath_bench
  import rcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] FL_BASE = 16'h5ac4; // other flags set, overflow set
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, wb_valid;
  logic [7:0]  awaddr, araddr, wb_seen;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] wb_data, wb_last;
  int          n_errors = 0, n_compared = 0, cycles = 0, n_case = 0;
  rcd_datapath dut (.*);
  rcd_wb_sink sink (.*);
  // clock
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;
  // watchdog
  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one write
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic fin;
    fin = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!fin) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        fin = 1'b1;
        check(32'(bresp), 32'(er));
      end
    end
  endtask : wr
  // one read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic fin;
    fin = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!fin) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        fin = 1'b1;
        d = rdata;
        check(32'(rresp), 32'(er));
      end
    end
  endtask : rd
  function automatic logic [31:0] mk(input logic [7:0] op, input int k, input logic [7:0] im);
    return {8'h00, im, 6'h00, k[1:0], op};
  endfunction : mk
  // reference: {carry, operand}
  function automatic logic [16:0] rot(input logic [1:0] k, input logic w, input logic [15:0] x,
                                      input logic c, input logic [7:0] n);
    logic t;
    for (int i = 0; i < n; i++) begin
      t = k[0] ? x[0] : (w ? x[15] : x[7]);
      if (k[0]) x = (x >> 1) | ({15'h0, k[1] ? c : t} << (w ? 15 : 7));
      else x = (x << 1) | {15'h0, k[1] ? c : t};
      if (!w) x[15:8] = 8'h00;
      c = t;
    end
    return {c, x};
  endfunction : rot
  // load, start, poll done, compare
  task automatic run_case(input logic [31:0] ins, input logic [15:0] opd, input logic [7:0] cnt,
                          input logic c, input logic [7:0] env);
    logic [7:0]  op, n, s0, b;
    logic [16:0] res;
    logic [15:0] fl;
    logic [31:0] st, m;
    logic        one, bad, gp, ss, i13, flt, wbx;
    op  = ins[7:0];
    one = op == 8'hd0 || op == 8'hd1;
    bad = !(one || op == 8'hd2 || op == 8'hd3 || op == 8'hc0 || op == 8'hc1);
    n   = one ? 8'h01 : ((op[7:4] == 4'hc ? ins[23:16] : cnt) & 8'h1f);
    gp  = env[1] && env[0] && (env[3] ? env[5:4] != 2'h2 : !env[2]);
    ss  = env[1] && env[0] && env[3] && env[5:4] == 2'h2;
    i13 = env[1] && !env[0] && op[0] && env[6];
    flt = bad || gp || ss || i13;
    wbx = env[1] && !flt && n != 8'h00;
    b   = one ? (env[1] ? 8'h07 : 8'h02) : (env[1] ? 8'h08 : 8'h05);
    m   = op[0] ? 32'hffff : 32'h00ff;
    res = flt ? {c, opd} : rot(ins[9:8], op[0], opd, c, n);
    fl  = FL_BASE;
    fl[0] = res[16];
    if (one && !flt) fl[11] = ins[9:8] == 2'h3 ? c ^ opd[op[0] ? 15 : 7] : res[16] ^ res[op[0] ? 15 : 7];
    s0 = wb_seen;
    st = 32'h0;
    wr(RCD_OFS_OPERAND, {16'h0, opd}, 2'h0);
    wr(RCD_OFS_COUNT, {24'h0, cnt}, 2'h0);
    wr(RCD_OFS_FLAGS, {16'h0, FL_BASE | {15'h0, c}}, 2'h0);
    wr(RCD_OFS_ENV, {24'h0, env}, 2'h0);
    wr(RCD_OFS_INSN, ins, 2'h0);
    for (int i = 0; i < 100 && st[RCD_ST_DONE] !== 1'b1; i++) rd(RCD_OFS_STATUS, st, 2'h0);
    check({25'h0, st[6:0]}, {25'h0, wbx, bad, i13, ss, gp, 2'b10});
    if (!flt) check({24'h0, st[15:8]}, {24'h0, b + n});
    rd(RCD_OFS_OPERAND, v, 2'h0);
    check(v & m, {15'h0, res} & m);
    rd(RCD_OFS_FLAGS, v, 2'h0);
    check(v, {16'h0, fl});
    check({24'h0, wb_seen}, {24'h0, s0 + {7'h0, wbx}});
    if (wbx) check({16'h0, wb_last} & m, {15'h0, res} & m);
    n_case++;
    $display("case %0d done", n_case);
  endtask : run_case
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf; // whole words only
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(RCD_OFS_FLAGS, v, 2'h0);
    check(v, {16'h0, RCD_FLAGS_RST});
    rd(RCD_OFS_ENV, v, 2'h0);
    check(v, RCD_ENV_RST);
    rd(8'h40, v, 2'h2);
    check(v, 32'h0);
    wr(RCD_OFS_STATUS, 32'h1, 2'h2);
    $display("register access done");
    for (int k = 0; k < 4; k++) begin
      run_case(mk(8'hd0, k, 8'h00), 16'h0081, 8'h00, k[0], 8'h04);
      run_case(mk(8'hd1, k, 8'h00), 16'h4001, 8'h00, !k[0], 8'h04);
    end
    run_case(mk(8'hd2, 2, 8'h00), 16'h00a5, 8'h09, 1'b1, 8'h04);
    run_case(mk(8'hc1, 3, 8'h11), 16'h1234, 8'h03, 1'b0, 8'h04);
    run_case(mk(8'hc0, 0, 8'h25), 16'h0096, 8'h00, 1'b0, 8'h04);
    run_case(mk(8'hd3, 1, 8'h00), 16'hbeef, 8'h23, 1'b1, 8'h04);
    run_case(mk(8'hd2, 1, 8'h00), 16'h0033, 8'h20, 1'b1, 8'h06);
    run_case(mk(8'hd0, 2, 8'h00), 16'h00c3, 8'h00, 1'b1, 8'h06);
    run_case(mk(8'hd3, 0, 8'h00), 16'h8421, 8'h1f, 1'b0, 8'h06);
    run_case(mk(8'hd3, 0, 8'h00), 16'h8421, 8'h05, 1'b0, 8'h03);
    run_case(mk(8'hd1, 0, 8'h00), 16'h8421, 8'h00, 1'b0, 8'h2f);
    run_case(mk(8'hd0, 1, 8'h00), 16'h0021, 8'h00, 1'b0, 8'h0f);
    run_case(mk(8'hd1, 1, 8'h00), 16'h0021, 8'h00, 1'b0, 8'h46);
    run_case(mk(8'hd0, 1, 8'h00), 16'h0021, 8'h00, 1'b0, 8'h46);
    run_case(mk(8'hd4, 0, 8'h00), 16'h0021, 8'h00, 1'b0, 8'h04);
    print_verdict();
  end
endmodule : rcd_datapath_bench
`default_nettype wire

// ===== rcd_datapath_chk.sv
// rcd_datapath_chk: port-level checks for the rotate datapath
// assumes one op at a time and writes committed as bvalid rises
`default_nettype none
module rcd_datapath_chk
  import rcd_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  // write-back
  input wire logic        wb_valid,
  input wire logic [15:0] wb_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  a_l, cnt_s, op, n;
  logic [31:0] d_l, env_s;
  logic        bv_q, start, one, okop, f_wr, f_ea, f_13, go_wb;
  logic        pend, k_wr, k_ea, k_13, k_zero;
  logic [5:0]  need;
  logic [6:0]  age;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // latch each bus item as it is taken
  always_ff @(posedge aclk) begin
    if (awvalid && awready) a_l <= awaddr;
    if (wvalid && wready) d_l <= wdata;
  end
  // shadow of env and count
  always_ff @(posedge aclk) begin
    bv_q <= bvalid && aresetn;
    if (!aresetn) begin
      env_s <= RCD_ENV_RST;
      cnt_s <= 8'h00;
    end else if (bvalid && !bv_q) begin
      if (a_l == RCD_OFS_ENV) env_s <= d_l;
      if (a_l == RCD_OFS_COUNT) cnt_s <= d_l[7:0];
    end
  end
  // start decode
  assign start = bvalid && !bv_q && a_l == RCD_OFS_INSN;
  assign op    = d_l[7:0];
  assign one   = op == RCD_OP_ONE_B || op == RCD_OP_ONE_W;
  assign okop  = one || op == RCD_OP_CNT_B || op == RCD_OP_CNT_W
                 || op == RCD_OP_IMM_B || op == RCD_OP_IMM_W;
  assign n     = one ? 8'h01 : ((op[7:4] == 4'hc ? d_l[23:16] : cnt_s) & 8'h1f);
  assign f_wr  = env_s[1] && env_s[0] && !env_s[3] && !env_s[2];
  assign f_ea  = env_s[1] && env_s[0] && env_s[3];
  assign f_13  = env_s[1] && !env_s[0] && op[0] && env_s[6];
  assign go_wb = okop && env_s[1] && !f_wr && !f_ea && !f_13 && n != 8'h00;
  // op age, write-back owed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend   <= 1'b0;
      age    <= 7'h00;
      need   <= 6'h00;
      k_wr   <= 1'b0;
      k_ea   <= 1'b0;
      k_13   <= 1'b0;
      k_zero <= 1'b0;
    end else if (start) begin
      pend   <= go_wb;
      age    <= 7'h00;
      need   <= (one ? RCD_CYC_ONE_MEM : RCD_CYC_CNT_MEM) + n[5:0];
      k_wr   <= f_wr;
      k_ea   <= f_ea;
      k_13   <= f_13;
      k_zero <= env_s[1] && n == 8'h00;
    end else begin
      if (wb_valid) pend <= 1'b0;
      if (age != 7'h7f) age <= age + 7'h01; // saturates, no wrap
    end
  end
  wb_pulse_a: assert property (wb_valid |=> !wb_valid)
    else $error("write-back pulse too long");
  wb_hold_a: assert property (!wb_valid |-> $stable(wb_data))
    else $error("write-back value moved");
  wb_early_a: assert property (wb_valid && pend |-> age + 7'h02 >= {1'b0, need})
    else $error("write-back too early");
  wb_late_a: assert property (pend |-> age <= {1'b0, need} + 7'h03)
    else $error("write-back too late");
  wr_prot_a: assert property (wb_valid |-> !k_wr)
    else $error("write-back to non-writable segment");
  bad_addr_a: assert property (start && f_ea |-> !wb_valid [*8])
    else $error("write-back after bad address");
  wrap_fault_a: assert property (wb_valid |-> !k_13 && !k_ea)
    else $error("write-back after offset wrap");
  zero_cnt_a: assert property (wb_valid |-> !k_zero)
    else $error("write-back with zero count");
  // write response follows both items
  b_late_a: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
    else $error("write response late");
  // read data stands until taken
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  // main scenarios
  c_wb: cover property (start && go_wb);
  c_fault: cover property (start && f_ea);
  c_zero: cover property (start && env_s[1] && n == 8'h00);
endmodule : rcd_datapath_chk
bind rcd_datapath rcd_datapath_chk chk (.*);
`default_nettype wire

// ===== rcd_pkg.sv
// rcd_pkg: constants and types for the rotate datapath
// assumes one core clock domain and an axi4-lite register port
`default_nettype none
package rcd_pkg;
  // register byte offsets
  localparam logic [7:0] RCD_OFS_INSN    = 8'h00;
  localparam logic [7:0] RCD_OFS_OPERAND = 8'h04;
  localparam logic [7:0] RCD_OFS_COUNT   = 8'h08;
  localparam logic [7:0] RCD_OFS_FLAGS   = 8'h0c;
  localparam logic [7:0] RCD_OFS_ENV     = 8'h10;
  localparam logic [7:0] RCD_OFS_STATUS  = 8'h14;
  localparam logic [7:0] RCD_OFS_RESULT  = 8'h18;
  // primary opcodes
  localparam logic [7:0] RCD_OP_ONE_B = 8'hd0;
  localparam logic [7:0] RCD_OP_ONE_W = 8'hd1;
  localparam logic [7:0] RCD_OP_CNT_B = 8'hd2;
  localparam logic [7:0] RCD_OP_CNT_W = 8'hd3;
  localparam logic [7:0] RCD_OP_IMM_B = 8'hc0;
  localparam logic [7:0] RCD_OP_IMM_W = 8'hc1;
  // flag word bit positions
  localparam int RCD_CARRY_BIT = 0;
  localparam int RCD_OVF_BIT   = 11;
  // env register bit positions
  localparam int RCD_ENV_PROT   = 0;
  localparam int RCD_ENV_MEM    = 1;
  localparam int RCD_ENV_WRABLE = 2;
  localparam int RCD_ENV_EABAD  = 3;
  localparam int RCD_ENV_SEG_LO = 4;
  localparam int RCD_ENV_LASTB  = 6;
  localparam logic [1:0] RCD_SEG_STACK = 2'h2;
  // status bit positions
  localparam int RCD_ST_BUSY  = 0;
  localparam int RCD_ST_DONE  = 1;
  localparam int RCD_ST_GP    = 2;
  localparam int RCD_ST_SS    = 3;
  localparam int RCD_ST_INT13 = 4;
  localparam int RCD_ST_BADOP = 5;
  localparam int RCD_ST_WB    = 6;
  localparam int RCD_ST_CYC   = 8;
  // count handling and cycle figures
  localparam logic [7:0] RCD_COUNT_MASK = 8'h1f;
  localparam logic [5:0] RCD_CYC_ONE_REG = 6'h02;
  localparam logic [5:0] RCD_CYC_ONE_MEM = 6'h07;
  localparam logic [5:0] RCD_CYC_CNT_REG = 6'h05;
  localparam logic [5:0] RCD_CYC_CNT_MEM = 6'h08;
  // reset values
  localparam logic [15:0] RCD_FLAGS_RST = 16'h0002;
  localparam logic [31:0] RCD_ENV_RST   = 32'h0000_0004;
  // operation selected by the specifier reg field
  typedef enum logic [1:0] {
    RCD_ROL = 2'h0,
    RCD_ROR = 2'h1,
    RCD_RCL = 2'h2,
    RCD_RCR = 2'h3
  } rcd_kind_type;
  typedef enum {RCD_IDLE, RCD_RUN} rcd_state_type;
endpackage : rcd_pkg
`default_nettype wire

// ===== rcd_step.sv
// rcd_step: one rotate step on a byte or word operand
// assumes byte operands sit in the low eight bits, upper bits zero
`default_nettype none
module rcd_step
  import rcd_pkg::*;
(
  // operand in
  input  wire logic [15:0] data_in,
  input  wire logic        carry_in,
  input  wire logic        is_word,
  input  wire logic [1:0]  kind,
  // operand out
  output logic      [15:0] data_out,
  output logic             carry_out
);
  logic top_bit;
  logic bot_bit;
  logic thru;
  logic left;

  // pick the ends of the operand by width
  always_comb begin
    top_bit = is_word ? data_in[15] : data_in[7];
    bot_bit = data_in[0];
    thru    = (kind == RCD_RCL) || (kind == RCD_RCR);
    left    = (kind == RCD_ROL) || (kind == RCD_RCL);
  end

  // one position of movement with the wrap bit
  always_comb begin
    data_out  = 16'h0000;
    carry_out = carry_in;
    if (left) begin
      // [RULE_04] left step wraps top
      data_out  = {data_in[14:0], 1'b0};
      // [RULE_06] carry into bottom bit
      data_out[0] = thru ? carry_in : top_bit;
      // [RULE_08] carry copies wrapped bit
      carry_out = top_bit;
    end else begin
      // [RULE_05] right step wraps bottom
      data_out = {1'b0, data_in[15:1]};
      // [RULE_07] carry into top bit
      if (is_word) begin
        data_out[15] = thru ? carry_in : bot_bit;
      end else begin
        data_out[7] = thru ? carry_in : bot_bit;
      end
      carry_out = bot_bit;
    end
    if (!is_word) begin
      data_out[15:8] = 8'h00;
    end
  end
endmodule : rcd_step
`default_nettype wire

// ===== rcd_wb_sink.sv
// rcd_wb_sink: memory side that takes the datapath's write-backs
// assumes wb_valid is a one-cycle pulse in the core clock domain
`default_nettype none
module rcd_wb_sink (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write-back from the datapath
  input  wire logic        wb_valid,
  input  wire logic [15:0] wb_data,
  // what memory now holds
  output logic      [7:0]  wb_seen,
  output logic      [15:0] wb_last
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wb_seen <= 8'h00;
      wb_last <= 16'h0000;
    end else if (wb_valid) begin
      wb_seen <= wb_seen + 8'h01; // counts pulses, not cycles
      wb_last <= wb_data;
    end
  end
endmodule : rcd_wb_sink
`default_nettype wire
